/* rtl/csr_pkg.sv */
// Purpose: shared constants and types of the register access block
// Assumes: byte addresses on an 8-bit register port with 32-bit data
// Notes:   every offset, field position, reset value and mask lives here once
package csr_pkg;

    // ****************************************
    // register port geometry
    // ****************************************
    localparam int          ADDR_W       = 8;          // byte address width
    localparam logic [3:0]  BE_FULL      = 4'hf;       // all four lanes enabled

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0]  ADDR_STA_LO  = 8'h00;      // station address bytes 0..3
    localparam logic [7:0]  ADDR_STA_HI  = 8'h04;      // station address bytes 4..5
    localparam logic [7:0]  ADDR_ETYPE   = 8'h08;      // two ethertype fields
    localparam logic [7:0]  ADDR_CTRL    = 8'h0c;      // control
    localparam logic [7:0]  ADDR_STATUS  = 8'h10;      // clear-on-read events
    localparam logic [7:0]  ADDR_CNT_LO  = 8'h14;      // frame counter bits 31:0
    localparam logic [7:0]  ADDR_CNT_HI  = 8'h18;      // frame counter bits 63:32

    // ****************************************
    // control register fields
    // ****************************************
    localparam int          CTRL_EN_BIT     = 0;       // block enable
    localparam int          CTRL_SPD_LSB    = 1;       // speed field, two bits
    localparam int          CTRL_AVAL_BIT   = 3;       // station address programmed
    localparam logic [31:0] CTRL_WR_MASK    = 32'h0000_0007;  // software-writable bits
    localparam logic [31:0] CTRL_RST        = 32'h0000_0000;  // reset value

    // ****************************************
    // status register fields
    // ****************************************
    localparam int          STAT_RX_BIT     = 0;       // receive event seen
    localparam int          STAT_WRAP_BIT   = 1;       // counter low word wrapped
    localparam logic [31:0] STAT_RST        = 32'h0000_0000;

    // ****************************************
    // data register reset values
    // ****************************************
    localparam logic [31:0] STA_LO_RST      = 32'h0000_0000;
    localparam logic [15:0] STA_HI_RST      = 16'h0000;
    localparam logic [31:0] ETYPE_RST       = 32'h0000_0000;
    localparam logic [63:0] CNT_RST         = 64'h0000_0000_0000_0000;

    // ****************************************
    // wire serialiser
    // ****************************************
    localparam int          SER_BYTES       = 8;       // bytes per transmission
    localparam int          SER_BITS        = SER_BYTES * 8;
    localparam logic [6:0]  SER_CNT_RST     = 7'h00;

    // access sequencer states
    typedef enum logic [0:0] {
        acc_idle,
        acc_answer
    } csr_acc_state_type;

endpackage

/* rtl/csr_wire_ser.sv */
// Purpose: shifts a fixed group of bytes onto a one-bit wire
// Assumes: load only while busy is low
// Notes:   lowest byte leaves first, each byte least significant bit first
`timescale 1ns/1ps
`default_nettype none
module csr_wire_ser (
    // clock and reset
    input  wire logic                          clock_in,
    input  wire logic                          rst_b_in,
    // load side
    input  wire logic                          load_in,
    input  wire logic [csr_pkg::SER_BITS-1:0]  data_in,
    output logic                               busy_out,
    // wire side
    output logic                               bit_out,
    output logic                               valid_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [csr_pkg::SER_BITS-1:0] sh;     // shift image, bit 0 next out
        logic [6:0]                   cnt;    // bits still to send
        logic                         bit_o;  // registered wire bit
        logic                         vld;    // registered wire valid
    } csr_ser_type;

    csr_ser_type q_ff;
    csr_ser_type nxt_q;

    // next state: a plain right shift keeps lsb-first at every byte boundary
    always_comb begin
        nxt_q = q_ff;
        if (load_in && q_ff.cnt == csr_pkg::SER_CNT_RST) begin
            nxt_q.bit_o = data_in[0];
            nxt_q.sh    = data_in >> 1;
            nxt_q.cnt   = 7'(csr_pkg::SER_BITS - 1);
            nxt_q.vld   = 1'b1;
        end else if (q_ff.cnt != csr_pkg::SER_CNT_RST) begin
            nxt_q.bit_o = q_ff.sh[0];
            nxt_q.sh    = q_ff.sh >> 1;
            nxt_q.cnt   = q_ff.cnt - 7'h01;
            nxt_q.vld   = 1'b1;
        end else begin
            nxt_q.vld   = 1'b0;
            nxt_q.bit_o = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bit_out   = q_ff.bit_o;
    assign valid_out = q_ff.vld;
    assign busy_out  = q_ff.vld;

    // ****************************************
    // checks
    // ****************************************
    chk_lsb_first_out: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (load_in && !q_ff.vld) |=> (bit_out == $past(data_in[0])) ##1 (bit_out == $past(data_in[1], 2)))
        else $error("wire bit order is not lsb first");

endmodule
`default_nettype wire

/* rtl/csr_access.sv */
// Purpose: register bank keeping the host access conventions of the controller
// Assumes: one register access at a time on the register port
// Notes:   a taken request answers with a one-cycle done one edge later
//
// Operation
// - wire bytes ascend, each byte lsb first; here ethertype lane 1 leaves before lane 0, lanes 3:2 are not sent
// - station address stored host little-endian order
// - ethertype fields stored network big-endian order
// - registers are 32 bits, written whole
// - partial-lane writes are dropped entirely
// - reads return all 32 bits always
// - partial read still clears clear-on-read register
// - reserved fields are read-only, keep init
// - wide counters split into 32-bit registers
// - only one access in flight at once
// - nvm, autoneg, reflected writes override defaults
// - undefined registers programmed before use
`timescale 1ns/1ps
`default_nettype none
module csr_access (
    // clock and reset
    input  wire logic                          clock_in,
    input  wire logic                          rst_b_in,
    // register port
    input  wire logic                          acc_req_in,
    input  wire logic                          acc_wr_in,
    input  wire logic [csr_pkg::ADDR_W-1:0]    acc_addr_in,
    input  wire logic [3:0]                    acc_be_in,
    input  wire logic [31:0]                   acc_wdata_in,
    output logic [31:0]                        acc_rdata_out,
    output logic                               acc_done_out,
    output logic                               acc_busy_out,
    // hardware events
    input  wire logic                          rx_event_in,
    input  wire logic                          frame_count_in,
    // default overrides
    input  wire logic                          nvm_load_in,
    input  wire logic                          nvm_valid_in,
    input  wire logic [31:0]                   nvm_data_in,
    input  wire logic                          an_done_in,
    input  wire logic [1:0]                    an_speed_in,
    // control outputs
    output logic                               ctrl_enable_out,
    output logic [1:0]                         ctrl_speed_out,
    // wire side
    input  wire logic                          tx_start_in,
    output logic                               wire_bit_out,
    output logic                               wire_valid_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        csr_pkg::csr_acc_state_type st;       // access sequencer
        logic [31:0]                rdata;    // read answer
        logic                       done;     // answer strobe
        logic [31:0]                sta_lo;   // station bytes 0..3
        logic [15:0]                sta_hi;   // station bytes 4..5
        logic [31:0]                etype;    // lanes 1:0 and 3:2 fields
        logic [31:0]                ctrl;     // control
        logic [31:0]                status;   // sticky events
        logic [63:0]                cnt;      // frame counter
        logic                       tx_load;  // serialiser load strobe
    } csr_regs_type;

    csr_regs_type q_ff;                       // registered state
    csr_regs_type nxt_q;                      // next state
    logic         ser_busy;                   // serialiser still sending
    logic         take;                       // request accepted this edge
    logic         wr_full;                    // whole-word write accepted
    logic         rd_take;                    // read accepted
    logic [31:0]  rd_mux;                     // selected read value
    logic [csr_pkg::SER_BITS-1:0] ser_data;   // bytes in wire order

    // requests seen during the answer cycle are ignored, not queued
    assign take    = acc_req_in && (q_ff.st == csr_pkg::acc_idle);
    assign wr_full = take && acc_wr_in && (acc_be_in == csr_pkg::BE_FULL);
    assign rd_take = take && !acc_wr_in;

    // read mux: full word regardless of lanes, zero where nothing lives
    always_comb begin
        unique case (acc_addr_in)
            csr_pkg::ADDR_STA_LO: rd_mux = q_ff.sta_lo;
            csr_pkg::ADDR_STA_HI: rd_mux = {16'h0000, q_ff.sta_hi};
            csr_pkg::ADDR_ETYPE:  rd_mux = q_ff.etype;
            csr_pkg::ADDR_CTRL:   rd_mux = q_ff.ctrl;
            csr_pkg::ADDR_STATUS: rd_mux = q_ff.status;
            csr_pkg::ADDR_CNT_LO: rd_mux = q_ff.cnt[31:0];
            csr_pkg::ADDR_CNT_HI: rd_mux = q_ff.cnt[63:32];
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        nxt_q         = q_ff;
        nxt_q.done    = 1'b0;
        nxt_q.tx_load = 1'b0;

        // access sequencer
        unique case (q_ff.st)
            csr_pkg::acc_idle: begin
                if (take) begin
                    nxt_q.st   = csr_pkg::acc_answer;
                    nxt_q.done = 1'b1;
                end
            end
            csr_pkg::acc_answer: begin
                nxt_q.st = csr_pkg::acc_idle;
            end
        endcase

        // read answer, lanes ignored
        if (rd_take) begin
            nxt_q.rdata = rd_mux;
        end

        // whole-word writes; partial and unmapped writes change nothing
        if (wr_full) begin
            unique case (acc_addr_in)
                csr_pkg::ADDR_STA_LO: begin
                    nxt_q.sta_lo = acc_wdata_in;
                end
                csr_pkg::ADDR_STA_HI: begin
                    nxt_q.sta_hi = acc_wdata_in[15:0];
                    // reflected write marks the address usable
                    nxt_q.ctrl[csr_pkg::CTRL_AVAL_BIT] = 1'b1;
                end
                csr_pkg::ADDR_ETYPE: begin
                    nxt_q.etype = acc_wdata_in;
                end
                csr_pkg::ADDR_CTRL: begin
                    // reserved and reflected bits keep their hardware value
                    nxt_q.ctrl = (acc_wdata_in & csr_pkg::CTRL_WR_MASK) |
                                 (nxt_q.ctrl & ~csr_pkg::CTRL_WR_MASK);
                end
                default: begin
                    nxt_q.rdata = q_ff.rdata;
                end
            endcase
        end

        // autoneg completion reflects its speed into control
        if (an_done_in) begin
            nxt_q.ctrl[csr_pkg::CTRL_SPD_LSB +: 2] = an_speed_in;
        end

        // a valid nvm load has the highest precedence
        if (nvm_load_in && nvm_valid_in) begin
            nxt_q.ctrl = (nvm_data_in & csr_pkg::CTRL_WR_MASK) |
                         (nxt_q.ctrl & ~csr_pkg::CTRL_WR_MASK);
        end

        // status: read clears all bits whatever the lanes, new events win
        if (rd_take && acc_addr_in == csr_pkg::ADDR_STATUS) begin
            nxt_q.status = csr_pkg::STAT_RST;
        end
        if (rx_event_in) begin
            nxt_q.status[csr_pkg::STAT_RX_BIT] = 1'b1;
        end

        // 64-bit counter, software sees it as two words
        if (frame_count_in) begin
            nxt_q.cnt = q_ff.cnt + 64'h0000_0000_0000_0001;
            if (q_ff.cnt[31:0] == 32'hffff_ffff) begin
                nxt_q.status[csr_pkg::STAT_WRAP_BIT] = 1'b1;
            end
        end

        // transmit only once the station address has been programmed
        if (tx_start_in && !ser_busy && !q_ff.tx_load && q_ff.ctrl[csr_pkg::CTRL_AVAL_BIT]) begin
            nxt_q.tx_load = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q_ff.st      <= csr_pkg::acc_idle;
            q_ff.rdata   <= 32'h0000_0000;
            q_ff.done    <= 1'b0;
            q_ff.sta_lo  <= csr_pkg::STA_LO_RST;
            q_ff.sta_hi  <= csr_pkg::STA_HI_RST;
            q_ff.etype   <= csr_pkg::ETYPE_RST;
            q_ff.ctrl    <= csr_pkg::CTRL_RST;
            q_ff.status  <= csr_pkg::STAT_RST;
            q_ff.cnt     <= csr_pkg::CNT_RST;
            q_ff.tx_load <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ****************************************
    // wire path
    // ****************************************
    // lanes 0..3 then 4..5 ascend; ethertype lane 1 leaves before lane 0
    assign ser_data = {q_ff.etype[7:0], q_ff.etype[15:8], q_ff.sta_hi, q_ff.sta_lo};

    csr_wire_ser i_csr_wire_ser (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .load_in   (q_ff.tx_load),
        .data_in   (ser_data),
        .busy_out  (ser_busy),
        .bit_out   (wire_bit_out),
        .valid_out (wire_valid_out)
    );

    // outputs straight from the state register
    assign acc_rdata_out   = q_ff.rdata;
    assign acc_done_out    = q_ff.done;
    assign acc_busy_out    = (q_ff.st == csr_pkg::acc_answer);
    assign ctrl_enable_out = q_ff.ctrl[csr_pkg::CTRL_EN_BIT];
    assign ctrl_speed_out  = q_ff.ctrl[csr_pkg::CTRL_SPD_LSB +: 2];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    chk_partial_write_drop: assert property (
        (take && acc_wr_in && acc_be_in != csr_pkg::BE_FULL) |=>
            ($stable(q_ff.sta_lo) && $stable(q_ff.sta_hi) && $stable(q_ff.etype)))
        else $error("partial write changed a register");

    chk_sta_lo_store: assert property (
        (wr_full && acc_addr_in == csr_pkg::ADDR_STA_LO) |=> (q_ff.sta_lo == $past(acc_wdata_in)))
        else $error("station low word not stored as written");

    chk_read_full_width: assert property (
        (rd_take && acc_addr_in == csr_pkg::ADDR_ETYPE) |=> (acc_rdata_out == $past(q_ff.etype)) && acc_done_out)
        else $error("read did not return the whole word");

    chk_cor_clears_all: assert property (
        (rd_take && acc_addr_in == csr_pkg::ADDR_STATUS && !rx_event_in && !frame_count_in)
            |=> (q_ff.status == csr_pkg::STAT_RST))
        else $error("status not cleared by read");

    chk_one_access: assert property (
        take |=> (acc_done_out && acc_busy_out) ##1 (!acc_done_out && !acc_busy_out))
        else $error("access answer timing wrong");

    chk_reserved_ctrl_zero: assert property (
        q_ff.ctrl[31:4] == 28'h0000000)
        else $error("reserved control bits set");

    chk_nvm_override: assert property (
        (nvm_load_in && nvm_valid_in) |=> (ctrl_enable_out == $past(nvm_data_in[csr_pkg::CTRL_EN_BIT])))
        else $error("nvm load did not override control");

    chk_unmapped_read_zero: assert property (
        (rd_take && acc_addr_in > csr_pkg::ADDR_CNT_HI) |=> (acc_rdata_out == 32'h0000_0000))
        else $error("unmapped read returned nonzero");

    chk_cnt_hi_word: assert property (
        (rd_take && acc_addr_in == csr_pkg::ADDR_CNT_HI) |=> (acc_rdata_out == $past(q_ff.cnt[63:32])))
        else $error("counter high word wrong");

    chk_tx_needs_addr: assert property (
        !q_ff.ctrl[csr_pkg::CTRL_AVAL_BIT] |=> !q_ff.tx_load)
        else $error("transmit before address programmed");

    chk_etype_first_byte: assert property (
        q_ff.tx_load |=> ##48 (wire_bit_out == $past(q_ff.etype[8], 49)))
        else $error("ethertype lane 1 not sent first");

    cov_partial_write: cover property (take && acc_wr_in && acc_be_in != csr_pkg::BE_FULL);
    cov_status_clear:  cover property (rd_take && acc_addr_in == csr_pkg::ADDR_STATUS && q_ff.status != 32'h0);
    cov_transmit:      cover property (q_ff.tx_load ##1 wire_valid_out [*8]);
    cov_nvm_load:      cover property (nvm_load_in && nvm_valid_in);

endmodule
`default_nettype wire

/* tb/test_csr_access.sv */
// Purpose: self-checking bench for the register access block
// Assumes: one access every three cycles, inputs driven 1 ns after the rising edge
// Notes:   expectations come from a small register model kept in the bench
`timescale 1ns/1ps
`default_nettype none
module test_csr_access;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        clock_in;
    logic        rst_b_in;
    logic        acc_req_in;
    logic        acc_wr_in;
    logic [7:0]  acc_addr_in;
    logic [3:0]  acc_be_in;
    logic [31:0] acc_wdata_in;
    logic [31:0] acc_rdata_out;
    logic        acc_done_out;
    logic        acc_busy_out;
    logic        rx_event_in;
    logic        frame_count_in;
    logic        nvm_load_in;
    logic        nvm_valid_in;
    logic [31:0] nvm_data_in;
    logic        an_done_in;
    logic [1:0]  an_speed_in;
    logic        ctrl_enable_out;
    logic [1:0]  ctrl_speed_out;
    logic        tx_start_in;
    logic        wire_bit_out;
    logic        wire_valid_out;
    // bench state: model registers, counters, seed
    logic [31:0] m_sta_lo, m_etype, m_ctrl, rd, d;
    logic [15:0] m_sta_hi;
    logic [63:0] w;              // expected wire image of one frame
    logic [7:0]  a;
    logic [3:0]  be;
    int          errors, n_checks, n;
    integer      seed = 32'hbf68cb5c;

    csr_access i_csr_access (.clock_in(clock_in), .rst_b_in(rst_b_in), .acc_req_in(acc_req_in),
        .acc_wr_in(acc_wr_in), .acc_addr_in(acc_addr_in), .acc_be_in(acc_be_in), .acc_wdata_in(acc_wdata_in),
        .acc_rdata_out(acc_rdata_out), .acc_done_out(acc_done_out), .acc_busy_out(acc_busy_out),
        .rx_event_in(rx_event_in), .frame_count_in(frame_count_in), .nvm_load_in(nvm_load_in),
        .nvm_valid_in(nvm_valid_in), .nvm_data_in(nvm_data_in), .an_done_in(an_done_in),
        .an_speed_in(an_speed_in), .ctrl_enable_out(ctrl_enable_out), .ctrl_speed_out(ctrl_speed_out),
        .tx_start_in(tx_start_in), .wire_bit_out(wire_bit_out), .wire_valid_out(wire_valid_out));

    // ****************************************
    // clock, watchdog, helpers
    // ****************************************
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // run needs well under 1500 cycles; a hang is cut off at 5000
    initial begin
        #50000;
        errors++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access; request held through the answer edge, where busy must refuse it
    task automatic acc(input logic wr, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] wd);
        @(posedge clock_in);
        #1;
        acc_req_in = 1'b1;
        acc_wr_in = wr;
        acc_addr_in = ad;
        acc_be_in = b;
        acc_wdata_in = wd;
        @(posedge clock_in);
        #1;
        chk({acc_done_out, acc_busy_out}, 2'b11);
        rd = acc_rdata_out;
        @(posedge clock_in);
        #1;
        chk({acc_done_out, acc_busy_out}, 2'b00);
        acc_req_in = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] exp);
        acc(1'b0, ad, b, $random(seed));
        chk(rd, exp);
    endtask
    // model: only whole-word writes land; reserved and unmapped read zero
    task automatic mdl_wr(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] wd);
        if (b == csr_pkg::BE_FULL) begin
            if (ad == csr_pkg::ADDR_STA_LO) m_sta_lo = wd;
            if (ad == csr_pkg::ADDR_STA_HI) m_sta_hi = wd[15:0];
            if (ad == csr_pkg::ADDR_STA_HI) m_ctrl[3] = 1'b1;
            if (ad == csr_pkg::ADDR_ETYPE) m_etype = wd;
            if (ad == csr_pkg::ADDR_CTRL) m_ctrl[2:0] = wd[2:0];
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic [7:0] ad);
        case (ad)
            csr_pkg::ADDR_STA_LO: return m_sta_lo;
            csr_pkg::ADDR_STA_HI: return {16'h0000, m_sta_hi};
            csr_pkg::ADDR_ETYPE:  return m_etype;
            csr_pkg::ADDR_CTRL:   return m_ctrl;
            default:              return 32'h0000_0000;
        endcase
    endfunction
    // software side: reserved positions carry their zero init value
    function automatic logic [31:0] no_rsvd(input logic [7:0] ad, input logic [31:0] wd);
        if (ad == csr_pkg::ADDR_CTRL) return wd & csr_pkg::CTRL_WR_MASK;
        if (ad == csr_pkg::ADDR_STA_HI) return wd & 32'h0000_ffff;
        return wd;
    endfunction
    // serial order: bit i of this value leaves in cycle i of the frame
    function automatic logic [63:0] exp_wire(input logic [31:0] lo, input logic [15:0] hi, input logic [31:0] et);
        return {et[7:0], et[15:8], hi, lo};
    endfunction
    task automatic tx_pulse();
        @(posedge clock_in);
        #1;
        tx_start_in = 1'b1;
        @(posedge clock_in);
        #1;
        tx_start_in = 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {acc_req_in, acc_wr_in, acc_addr_in, acc_be_in, acc_wdata_in} = '0;
        {rx_event_in, frame_count_in, nvm_load_in, nvm_valid_in, nvm_data_in} = '0;
        {an_done_in, an_speed_in, tx_start_in} = '0;
        {m_sta_lo, m_etype, m_ctrl, m_sta_hi} = '0;
        errors = 0;
        n_checks = 0;
        rst_b_in = 1'b0;
        repeat (5) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        // reset values, including the unmapped slot after the counter
        for (int i = 0; i < 32; i += 4) rd_chk(i[7:0], 4'hf, 32'h0000_0000);
        // transmit stays off until the station address is programmed
        tx_pulse();
        repeat (6) begin
            @(posedge clock_in);
            #1;
            chk(wire_valid_out, 1'b0);
        end
        $display("test reset done");
        // random full and partial writes, read back under random byte enables
        for (int i = 0; i < 16; i++) begin
            a = 8'(($random(seed) & 3) * 4);
            be = (i % 3 == 0) ? 4'hf : 4'($random(seed));
            d = no_rsvd(a, $random(seed));
            acc(1'b1, a, be, d);
            mdl_wr(a, be, d);
            rd_chk(a, 4'($random(seed)), exp_rd(a));
            chk({ctrl_speed_out, ctrl_enable_out}, m_ctrl[2:0]);
        end
        $display("test random access done");
        // unmapped and read-only offsets ignore writes, unmapped reads zero
        acc(1'b1, 8'h40, 4'hf, 32'hffff_ffff);
        acc(1'b1, csr_pkg::ADDR_STATUS, 4'hf, 32'h0000_0003);
        acc(1'b1, csr_pkg::ADDR_CNT_LO, 4'hf, 32'hffff_ffff);
        rd_chk(8'h40, 4'hf, 32'h0000_0000);
        rd_chk(csr_pkg::ADDR_STATUS, 4'hf, 32'h0000_0000);
        rd_chk(csr_pkg::ADDR_CNT_LO, 4'hf, 32'h0000_0000);
        $display("test unmapped done");
        // clear-on-read through a one-lane read
        @(posedge clock_in);
        #1;
        rx_event_in = 1'b1;
        @(posedge clock_in);
        #1;
        rx_event_in = 1'b0;
        rd_chk(csr_pkg::ADDR_STATUS, 4'h2, 32'h0000_0001);
        rd_chk(csr_pkg::ADDR_STATUS, 4'hf, 32'h0000_0000);
        // wide counter read as two independent words
        n = 1 + ($random(seed) & 31);
        @(posedge clock_in);
        #1;
        frame_count_in = 1'b1;
        repeat (n) @(posedge clock_in);
        #1;
        frame_count_in = 1'b0;
        rd_chk(csr_pkg::ADDR_CNT_LO, 4'hf, 32'(n));
        rd_chk(csr_pkg::ADDR_CNT_HI, 4'hf, 32'h0000_0000);
        $display("test status and counter done");
        // default overrides: valid load, ignored invalid load, autoneg speed
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_in);
            #1;
            nvm_data_in = $random(seed);
            an_speed_in = 2'($random(seed));
            nvm_valid_in = (i != 1);
            nvm_load_in = (i != 2);
            an_done_in = (i == 2);
            if (i == 0) m_ctrl[2:0] = nvm_data_in[2:0];
            if (i == 2) m_ctrl[2:1] = an_speed_in;
            @(posedge clock_in);
            #1;
            {nvm_load_in, an_done_in} = 2'b00;
            rd_chk(csr_pkg::ADDR_CTRL, 4'hf, m_ctrl);
            chk({ctrl_speed_out, ctrl_enable_out}, m_ctrl[2:0]);
        end
        $display("test overrides done");
        // full frame on the wire after programming both address words
        for (int i = 0; i < 3; i++) begin
            d = no_rsvd(8'(i * 4), $random(seed));
            acc(1'b1, 8'(i * 4), 4'hf, d);
            mdl_wr(8'(i * 4), 4'hf, d);
        end
        w = exp_wire(m_sta_lo, m_sta_hi, m_etype);
        tx_pulse();
        @(posedge clock_in);
        for (int i = 0; i < 64; i++) begin
            #1;
            chk({wire_valid_out, wire_bit_out}, {1'b1, w[i]});
            @(posedge clock_in);
        end
        #1;
        chk(wire_valid_out, 1'b0);
        $display("test wire done");
        wrap_up();
    end
endmodule
`default_nettype wire
